//--- rtl/uotg_status_flags.sv
`timescale 1ns/10ps
`include "uotg_defines.svh"
module uotg_status_flags
    import uotg_pkg::*;
#(
    parameter int MS_CYCLES = `UOTG_MS_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic id_pin,
    input wire logic dplus_pin,
    input wire logic dminus_pin,
    input wire logic se0_line,
    input wire logic j_line_state,
    input wire logic vbus_activity,
    input wire logic a_sess_end_cmp,
    input wire logic b_sess_end_cmp,
    input wire logic a_vbus_valid_cmp,
    output logic vbus_pullup_en,
    output logic ext_module_serial_ctrl_sel,
    output logic irq
);
    // Input synchronisers, one per pin, two stages each
    localparam int NIN = 9;
    // Bit positions inside the synchroniser vectors
    localparam int IX_ID = 0;
    localparam int IX_DP = 1;
    localparam int IX_DM = 2;
    localparam int IX_SE0 = 3;
    localparam int IX_J = 4;
    localparam int IX_VACT = 5;
    localparam int IX_ASE = 6;
    localparam int IX_BSE = 7;
    localparam int IX_AVB = 8;

    logic [NIN-1:0] pin_raw;
    logic [NIN-1:0] sync1_q;
    logic [NIN-1:0] sync2_q;
    logic [NIN-1:0] prev_q;
    assign pin_raw = {a_vbus_valid_cmp, b_sess_end_cmp, a_sess_end_cmp, vbus_activity,
                      j_line_state, se0_line, dminus_pin, dplus_pin, id_pin};
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    prev_q[gi] <= sync2_q[gi];
                end
            end
        end
    endgenerate
    // Edges only after the first sampled value settles, to avoid a bogus reset event
    logic primed_q;
    logic [1:0] primed_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primed_cnt_q <= 2'b00;
            primed_q <= 1'b0;
        end else if (!primed_q) begin
            primed_cnt_q <= primed_cnt_q + 2'b01;
            primed_q <= (primed_cnt_q == 2'b10);
        end
    end
    // One-cycle pulse on every change of a synchronised level
    wire [NIN-1:0] edge_w = (sync2_q ^ prev_q) & {NIN{primed_q}};

    // One millisecond timer
    // Free-running from reset, so the first tick after a clear may come early
    logic [31:0] ms_cnt_q;
    wire ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_cnt_q <= 32'h00000000;
        end else if (ms_tick) begin
            ms_cnt_q <= 32'h00000000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h00000001;
        end
    end

    // Line-state stability: state = {se0, j}
    // Reported state starts at 00, so a first stable non-idle state is flagged
    wire [1:0] line_now = {sync2_q[IX_SE0], sync2_q[IX_J]};
    logic [1:0] line_cand_q;
    logic [1:0] line_rep_q;
    logic [31:0] line_cnt_q;
    wire line_chg = (line_now != line_cand_q);
    wire line_full = (line_cnt_q == 32'(MS_CYCLES - 1));
    wire line_evt = line_full && !line_chg && (line_cand_q != line_rep_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_cand_q <= 2'b00;
            line_rep_q <= 2'b00;
            line_cnt_q <= 32'h00000000;
        end else begin
            if (line_chg) begin
                line_cand_q <= line_now;
                line_cnt_q <= 32'h00000000;
            end else if (!line_full) begin
                line_cnt_q <= line_cnt_q + 32'h00000001;
            end
            if (line_evt) begin
                line_rep_q <= line_cand_q;
            end
        end
    end

    // Hardware set events, one per flag
    wire id_evt = edge_w[IX_ID];
    wire dline_evt = edge_w[IX_DP] | edge_w[IX_DM];
    // Activity level re-sets the flag every cycle, so a clear cannot stick while high
    wire act_evt = dline_evt | sync2_q[IX_VACT];
    // Either crossing direction is an edge of the comparator level
    wire asess_evt = edge_w[IX_ASE];
    wire bsess_evt = edge_w[IX_BSE];
    wire avb_evt = edge_w[IX_AVB];

    logic [15:0] set_w;
    always_comb begin
        set_w = 16'h0000;
        set_w[`UOTG_BIT_ID] = id_evt;
        set_w[`UOTG_BIT_TMR] = ms_tick;
        set_w[`UOTG_BIT_LST] = line_evt;
        set_w[`UOTG_BIT_ACT] = act_evt;
        set_w[`UOTG_BIT_SESV] = asess_evt;
        set_w[`UOTG_BIT_BSES] = bsess_evt;
        set_w[`UOTG_BIT_AVB] = avb_evt;
    end

    // AXI4-Lite write path: address and data taken in either order
    uotg_wst_t wst_q;
    logic aw_have_q;
    logic w_have_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_ok = aw_have_q || aw_take;
    wire w_ok = w_have_q || w_take;
    wire [3:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
    wire [3:0] ws = w_have_q ? wstrb_q : s_axi_wstrb;
    wire do_wr = (wst_q == UOTG_W_IDLE) && aw_ok && w_ok;
    wire wr_lo = do_wr && ws[0];
    wire wr_hi = do_wr && ws[1];
    wire [15:0] wmask = {{8{wr_hi}}, {8{wr_lo}}};
    wire wr_cfg = (wa == `UOTG_ADDR_CFG2);
    wire wr_flg = (wa == `UOTG_ADDR_FLAGS);
    wire wr_msk = (wa == `UOTG_ADDR_MASK);
    // Status is clear-on-read only; a write to it is accepted and ignored
    wire wr_sts = (wa == `UOTG_ADDR_STAT);
    wire wr_map = wr_cfg || wr_flg || wr_msk || wr_sts;
    wire [1:0] bresp_d = wr_map ? 2'b00 : 2'b10;
    // One write outstanding: both readys stay low until the response is taken

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q <= UOTG_W_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            case (wst_q)
                UOTG_W_IDLE: begin
                    if (aw_take) begin
                        aw_have_q <= 1'b1;
                        awaddr_q <= s_axi_awaddr;
                    end
                    if (w_take) begin
                        w_have_q <= 1'b1;
                        wdata_q <= s_axi_wdata;
                        wstrb_q <= s_axi_wstrb;
                    end
                    s_axi_awready <= !aw_ok;
                    s_axi_wready <= !w_ok;
                    if (do_wr) begin
                        aw_have_q <= 1'b0;
                        w_have_q <= 1'b0;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= bresp_d;
                        wst_q <= UOTG_W_RESP;
                    end
                end
                UOTG_W_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wst_q <= UOTG_W_IDLE;
                    end
                end
                default: begin
                    wst_q <= UOTG_W_IDLE;
                end
            endcase
        end
    end

    // Registers
    logic [15:0] cfg_q;
    logic [15:0] flags_q;
    logic [15:0] mask_q;
    logic [15:0] stat_q;
    logic rd_stat;
    wire [15:0] cfg_d = wr_cfg ? ((cfg_q & ~wmask) | (wd[15:0] & wmask & `UOTG_CFG2_MASK))
                               : cfg_q;
    wire [15:0] clr_w = (wr_flg ? (wd[15:0] & wmask) : 16'h0000);
    // Set applied after clear so a simultaneous event survives
    wire [15:0] flags_d = ((flags_q & ~clr_w) | set_w) & `UOTG_FLAG_MASK;
    wire [15:0] mask_d = wr_msk ? ((mask_q & ~wmask) | (wd[15:0] & wmask)) : mask_q;
    wire [15:0] stat_d = ((rd_stat ? 16'h0000 : stat_q) | set_w) & `UOTG_FLAG_MASK;
    wire pullup_d = cfg_d[`UOTG_BIT_PUVB];
    wire sel_d = cfg_d[`UOTG_BIT_SEL];
    // Built from next values so irq moves on the same edge as the status it reflects
    wire irq_d = |(stat_d & mask_d);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= `UOTG_RST_16;
            flags_q <= `UOTG_RST_16;
            mask_q <= `UOTG_RST_16;
            stat_q <= `UOTG_RST_16;
            vbus_pullup_en <= 1'b0;
            ext_module_serial_ctrl_sel <= 1'b0;
            irq <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            flags_q <= flags_d;
            mask_q <= mask_d & `UOTG_FLAG_MASK;
            stat_q <= stat_d;
            vbus_pullup_en <= pullup_d;
            ext_module_serial_ctrl_sel <= sel_d;
            irq <= irq_d;
        end
    end

    // AXI4-Lite read path
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [3:0] ra = s_axi_araddr;
    wire rd_cfg = (ra == `UOTG_ADDR_CFG2);
    wire rd_flg = (ra == `UOTG_ADDR_FLAGS);
    wire rd_msk = (ra == `UOTG_ADDR_MASK);
    wire rd_sts = (ra == `UOTG_ADDR_STAT);
    wire ra_map = rd_cfg || rd_flg || rd_msk || rd_sts;
    wire [15:0] rsel = rd_cfg ? cfg_q :
                       rd_flg ? flags_q :
                       rd_msk ? mask_q :
                       rd_sts ? stat_q : 16'h0000;
    wire [1:0] rresp_d = ra_map ? 2'b00 : 2'b10;
    // Reading the status word clears it; an event in the same cycle still lands
    assign rd_stat = ar_take && rd_sts;
    // arready stays low while an answer stands, so one read at most is under way
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rsel};
            s_axi_rresp <= rresp_d;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule // uotg_status_flags

//--- rtl/uotg_defines.svh
// How it works
// - Pull-up bit set drives the VBUS pull-up enable high; clear turns it off.
// - Serial-control select bit picks I2C control of external modules, else pins.
// - Config register reads zero outside bits 4 and 3; only those are writable.
// - Any change on the synchronised ID input sets the ID-change flag.
// - Expiry of the free-running one millisecond timer sets the timer flag.
// - Line state stable for 1 ms and unlike last reported sets line-stable flag.
// - Any edge on D+ or D-, or VBUS activity high, sets the bus-activity flag.
// - Crossing of the A session-end threshold, either way, sets session-valid flag.
// - Crossing of the B session-end threshold sets the B-side VBUS flag.
// - Crossing of the A VBUS-valid threshold sets the A-side VBUS flag.
// - Rising and falling threshold crossings both count as events.
// - Flag register holds host-mode flags; bits 15-8 and 1 read zero.
// - Writing one clears a flag; writing zero leaves it alone.
`ifndef UOTG_DEFINES_SVH
`define UOTG_DEFINES_SVH
`define UOTG_ADDR_CFG2 4'h0
`define UOTG_ADDR_FLAGS 4'h4
`define UOTG_ADDR_MASK 4'h8
`define UOTG_ADDR_STAT 4'hC
`define UOTG_CFG2_MASK 16'h0018
`define UOTG_BIT_PUVB 4
`define UOTG_BIT_SEL 3
`define UOTG_BIT_ID 7
`define UOTG_BIT_TMR 6
`define UOTG_BIT_LST 5
`define UOTG_BIT_ACT 4
`define UOTG_BIT_SESV 3
`define UOTG_BIT_BSES 2
`define UOTG_BIT_AVB 0
`define UOTG_FLAG_MASK 16'h00FD
`define UOTG_RST_16 16'h0000
`define UOTG_MS_NS 1000000
`define UOTG_CLK_NS 100
`define UOTG_MS_CYC (`UOTG_MS_NS / `UOTG_CLK_NS)
`endif

//--- rtl/uotg_pkg.sv
package uotg_pkg;
    typedef enum logic [1:0] {
        UOTG_W_IDLE = 2'b01,
        UOTG_W_RESP = 2'b10
    } uotg_wst_t;
endpackage

//--- tb/uotg_checker.sv
`timescale 1ns/10ps
module uotg_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic vbus_pullup_en,
    input wire logic ext_module_serial_ctrl_sel,
    input wire logic irq
);
    logic [3:0] rd_addr_q;
    wire rd_cfg = s_axi_rvalid && rd_addr_q == 4'h0;
    wire rd_flags = s_axi_rvalid && rd_addr_q == 4'h4;
    always_ff @(posedge aclk) begin
        if (!aresetn) rd_addr_q <= 4'h0;
        else if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_cfg_spare: assert property (
        rd_cfg |-> (s_axi_rdata & ~32'h18) == 32'h0) else $error("config spare bits set");
    chk_cfg_pullup: assert property (
        rd_cfg |-> s_axi_rdata[4] == vbus_pullup_en) else $error("pull-up bit mismatch");
    chk_cfg_sel: assert property (
        rd_cfg |-> s_axi_rdata[3] == ext_module_serial_ctrl_sel) else $error("select mismatch");
    chk_flag_spare: assert property (
        rd_flags |-> s_axi_rdata[15:8] == 8'h0 && !s_axi_rdata[1]) else $error("flag spare set");
    chk_pullup_write: assert property (
        $changed(vbus_pullup_en) |-> $rose(s_axi_bvalid)) else $error("pull-up moved alone");
    chk_sel_write: assert property (
        $changed(ext_module_serial_ctrl_sel) |-> $rose(s_axi_bvalid)) else $error("sel moved");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    chk_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_write_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer dropped");
    cov_read: cover property (rd_flags);
    cov_pullup: cover property ($rose(vbus_pullup_en));
    cov_irq: cover property ($rose(irq));
endmodule // uotg_checker
bind uotg_status_flags uotg_checker u_chk (.*);

//--- tb/uotg_line_model.sv
`timescale 1ns/10ps
module uotg_line_model (
    input wire logic aclk,
    output logic [8:0] lines
);
    // Quiet cable; levels only move just after an edge
    initial lines = 9'h000;
    task automatic set(input int i, input logic v);
        @(posedge aclk);
        lines[i] <= v;
    endtask
endmodule // uotg_line_model

//--- tb/usb_otg_status_flags_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module usb_otg_status_flags_bench;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_arready, s_axi_rvalid, irq, vbus_pullup_en, ext_module_serial_ctrl_sel;
    logic id_pin, dplus_pin, dminus_pin, se0_line, j_line_state, vbus_activity;
    logic a_sess_end_cmp, b_sess_end_cmp, a_vbus_valid_cmp;
    logic [8:0] lines;
    int n_fail = 0, samples_checked = 0;
    int li[7] = '{0, 1, 2, 5, 6, 7, 8};
    logic [15:0] fb[7] = '{16'h80, 16'h10, 16'h10, 16'h10, 16'h08, 16'h04, 16'h01};
    uotg_status_flags #(.MS_CYCLES(20)) u_dut (.*);
    uotg_line_model u_line (.aclk(aclk), .lines(lines));
    assign {a_vbus_valid_cmp, b_sess_end_cmp, a_sess_end_cmp, vbus_activity} = lines[8:5];
    assign {j_line_state, se0_line, dminus_pin, dplus_pin, id_pin} = lines[4:0];
    initial forever #50 aclk = ~aclk;
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        bit b = 0;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin b = 1; resp = s_axi_bresp; s_axi_bready <= 0; end
        end
    endtask
    task automatic rd(input logic [3:0] a);
        bit b = 0;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin b = 1; d = s_axi_rdata; resp = s_axi_rresp; s_axi_rready <= 0; end
        end
    endtask
    task automatic rf(input string n, input logic [3:0] a, input logic [15:0] m, e);
        rd(a);
        `CHK(n, e, d[15:0] & m)
    endtask
    task automatic clr; repeat (6) @(posedge aclk); wr(4'h4, 32'hFD); endtask
    task automatic pin(input int i, input logic v); u_line.set(i, v); repeat (6) @(posedge aclk); endtask
    task automatic t_cfg;
        rf("cfg reset", 4'h0, 16'hFFFF, 16'h0);
        wr(4'h0, 32'hFFFFFFFF); `CHK("pullup on", 1'h1, vbus_pullup_en)
        `CHK("serial sel", 1'h1, ext_module_serial_ctrl_sel)
        rf("cfg all", 4'h0, 16'hFFFF, 16'h0018);
        wr(4'h0, 32'h10); `CHK("pin sel", 1'h0, ext_module_serial_ctrl_sel)
        wr(4'h0, 32'h8); `CHK("pullup off", 1'h0, vbus_pullup_en)
        wr(4'h2, 32'h0); `CHK("bresp", 2'h2, resp)
        rd(4'h6); `CHK("rresp", 2'h2, resp)
    endtask
    task automatic t_evt;
        for (int i = 0; i < 7; i++) begin
            clr(); pin(li[i], 1);
            rf("rise", 4'h4, 16'hFFBF, fb[i]);
            clr(); pin(li[i], 0);
            if (li[i] != 5) rf("fall", 4'h4, 16'hFFBF, fb[i]);
        end
        clr(); pin(0, 1); pin(8, 1);
        wr(4'h4, 32'h80); rf("w1c", 4'h4, 16'hFFBF, 16'h1);
        wr(4'h4, 32'h0); rf("w0", 4'h4, 16'hFFBF, 16'h1);
        pin(0, 0); pin(8, 0);
        clr(); u_line.set(0, 1); @(posedge aclk);
        wr(4'h4, 32'h80); rf("set wins", 4'h4, 16'h80, 16'h80);
        pin(0, 0);
    endtask
    task automatic t_line;
        clr(); pin(4, 1); repeat (30) @(posedge aclk);
        rf("line", 4'h4, 16'h20, 16'h20);
        clr(); repeat (30) @(posedge aclk);
        rf("line same", 4'h4, 16'h20, 16'h0);
        rf("tick", 4'h4, 16'h40, 16'h40);
        pin(4, 0);
    endtask
    task automatic t_irq;
        wr(4'h8, 32'h80); rf("mask", 4'h8, 16'hFFFF, 16'h80);
        rd(4'hC); repeat (3) @(posedge aclk); pin(0, 1);
        `CHK("irq up", 1'h1, irq)
        rf("status", 4'hC, 16'h80, 16'h80);
        repeat (3) @(posedge aclk); `CHK("irq read clr", 1'h0, irq)
        wr(4'h8, 32'h0); pin(0, 0); `CHK("irq masked", 1'h0, irq)
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        repeat (4) @(posedge aclk);
        `CHK("irq reset", 1'h0, irq)
        t_cfg(); t_evt(); t_line(); t_irq();
        summarize();
    end
    initial begin
        #3000000;
        n_fail++;
        summarize();
    end
endmodule // usb_otg_status_flags_bench
